// file: core/smbus_master_slave_controller.sv
// Operation
// - Bit rate up to sysclk over twenty
// - START, address, data bytes, then STOP
// - Address bit zero: 1 read, 0 write
// - ACK is SDA low during high SCL
// - Master writes bytes, awaits slave ACK
// - Slave sends read bytes, awaits master ACK
// - Master ends transfer with STOP
// - Sender drives byte, receiver drives ACK
// - Master starts only on free bus
// - Released high but seen low: lose
// - Loser continues as slave if addressed
// - Master waits for released SCL high
// - SCL low timeout resets communication
// - Per-instance timer counts SCL low time
// - Timer reloads high, counts SCL low
// - Free after more than ten idle bit clocks
// - Pending START issued once bus frees
// - Free timeout needs bit clock running
// - Software or hardware address and ACK
// - Processor moves bytes, hardware shifts bits
// - Lines only pulled low, open drain
// - Both instances identical apart from timers
// - Event timing around ACK by mode
// - Bit rate one third of ticks
module smbus_master_slave_controller #(
	parameter int FREE_TICKS = smbus_pkg::FREE_TIMEOUT_TICKS
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       enable,
	input  wire logic       slaveInhibit,
	input  wire logic       hwAckEnable,
	input  wire logic       sclLowTimeoutEnable,
	input  wire logic       busFreeTimeoutEnable,
	input  wire logic [6:0] slaveAddr,
	input  wire logic       bitClockTick,
	input  wire logic       sclLowTimerOvf,
	input  wire logic       cmdStart,
	input  wire logic       cmdStop,
	input  wire logic       cmdGo,
	input  wire logic [7:0] txData,
	input  wire logic       ackOut,
	input  wire logic       flagClear,
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	output logic            sclOut,
	output logic            sclOe,
	output logic            sdaOut,
	output logic            sdaOe,
	output logic            sclLowTimerReload,
	output logic            byteEvent,
	output logic            arbLostEvent,
	output logic            sclTimeoutEvent,
	output logic [7:0]      rxData,
	output logic            ackReceived,
	output logic            masterMode,
	output logic            transmitMode,
	output logic            busBusy
);

	// ****************************************
	// Line sensing and bus-free tracking
	// ****************************************
	bus_sense_if bus ();

	// Pins are asynchronous: sampler holds the synchronisers
	line_sampler u_sampler (
		.clk     (clk),
		.sys_rst (sys_rst),
		.sclIn   (sclIn),
		.sdaIn   (sdaIn),
		.bus     (bus.sampler)
	);

	// Free timeout runs on the selected bit clock overflows
	bus_free_monitor #(
		.FREE_TICKS (FREE_TICKS)
	) u_monitor (
		.clk                  (clk),
		.sys_rst              (sys_rst),
		.bitClockTick         (bitClockTick),
		.busFreeTimeoutEnable (busFreeTimeoutEnable),
		.bus                  (bus.monitor)
	);

	// ****************************************
	// Helpers
	// ****************************************
	// True when we drive SDA on data bits of the byte
	function automatic logic isTx(input logic master, input logic addrPh,
		input logic dirRead);
		isTx = addrPh ? master
			: (master ? (dirRead != smbus_pkg::DIR_READ)
			: (dirRead == smbus_pkg::DIR_READ));
	endfunction : isTx

	// Whether SDA is pulled low during the current bit
	function automatic logic sdaLow(input smbus_pkg::ctl_t c);
		logic tx;
		tx = isTx(c.master, c.addrPh, c.dirRead);
		if (c.bitCnt == smbus_pkg::ACK_BIT) begin
			sdaLow = !tx && c.ackAssert;
		end else begin
			sdaLow = tx && (c.shift[7] == smbus_pkg::DRIVE_LEVEL);
		end
	endfunction : sdaLow

	smbus_pkg::ctl_t q; // Registered state
	smbus_pkg::ctl_t d; // Next state
	logic            adv;     // Bit finished, move on
	logic            tmoHit;  // SCL low timeout fired
	logic            curTx;   // Current byte transmitted by us

	assign tmoHit = sclLowTimeoutEnable && sclLowTimerOvf;
	assign curTx  = isTx(q.master, q.addrPh, q.dirRead);

	// ****************************************
	// Sequencer
	// ****************************************
	// One process computes every next value of the state record
	always_comb begin
		adv = 1'b0;
		d = q;
		d.reload = enable && sclLowTimeoutEnable && bus.sclS;
		d.busy = !bus.busFree;
		d.lowLevel = smbus_pkg::DRIVE_LEVEL;
		// Clear first so a same-cycle set below wins
		if (flagClear) begin
			d.evt = 1'b0;
			d.arb = 1'b0;
			d.tmo = 1'b0;
		end
		// Address byte is kept apart from the shifter
		if (cmdStart && q.st == smbus_pkg::ST_IDLE) begin
			d.startPend = 1'b1;
			d.pendAddr = txData;
		end
		case (q.st)
			smbus_pkg::ST_IDLE: begin
				// Wait for free bus, also after free timeout
				if (q.startPend && bus.busFree) begin
					d.st = smbus_pkg::ST_START;
					d.startPend = 1'b0;
					d.master = 1'b1;
					d.addrPh = 1'b1;
					d.shift = q.pendAddr;
					d.dirRead = q.pendAddr[smbus_pkg::ADDR_DIR_BIT];
					d.sdaOe = 1'b1;
				end
			end
			smbus_pkg::ST_START: begin
				// SDA low held a tick, then clock goes low
				if (bitClockTick) begin
					d.sclOe = 1'b1;
					d.bitCnt = smbus_pkg::FIRST_BIT;
					d.st = smbus_pkg::ST_LOW;
				end
			end
			smbus_pkg::ST_LOW: begin
				if (q.master) begin
					// Release only once SDA has settled
					if (bitClockTick && !bus.sclS && q.sdaOe == sdaLow(q)) begin
						d.sclOe = 1'b0;
						d.sampled = 1'b0;
						d.tickCnt = '0;
						d.st = smbus_pkg::ST_HIGH;
					end
				end else if (bus.sclRise) begin
					d.sampled = 1'b1;
					d.st = smbus_pkg::ST_HIGH;
					if (q.bitCnt == smbus_pkg::ACK_BIT) begin
						d.ackSeen = (bus.sdaS == smbus_pkg::ACK_LEVEL);
					end else begin
						d.shift = {q.shift[6:0], bus.sdaS};
					end
				end
			end
			smbus_pkg::ST_HIGH: begin
				if (!q.master) begin
					if (bus.sclFall) begin
						adv = 1'b1;
					end
				end else if (!q.sampled) begin
					// A stretching slave keeps us here
					if (bus.sclS) begin
						d.sampled = 1'b1;
						if (q.bitCnt == smbus_pkg::ACK_BIT) begin
							d.ackSeen = (bus.sdaS == smbus_pkg::ACK_LEVEL);
						end else begin
							d.shift = {q.shift[6:0], bus.sdaS};
						end
						// Released high yet read low: another master won
						if (curTx && q.bitCnt != smbus_pkg::ACK_BIT &&
							!q.sdaOe && !bus.sdaS) begin
							d.arb = 1'b1;
							d.master = 1'b0;
							d.sclOe = 1'b0;
							if (!q.addrPh) begin
								d.st = smbus_pkg::ST_IDLE;
							end
						end
					end
				end else if (bitClockTick) begin
					d.tickCnt = q.tickCnt + 2'h1;
					if (q.tickCnt == smbus_pkg::HIGH_TICKS - 2'h1) begin
						d.sclOe = 1'b1;
						adv = 1'b1;
					end
				end
			end
			smbus_pkg::ST_HOLD: begin
				// Software picks the outgoing ACK while SCL is held
				if (cmdGo) begin
					d.ackAssert = ackOut;
					d.stopAfter = cmdStop;
					d.bitCnt = smbus_pkg::ACK_BIT;
					d.sclOe = q.master;
					d.st = smbus_pkg::ST_LOW;
				end
			end
			smbus_pkg::ST_WAIT: begin
				if (q.master && cmdStop) begin
					d.st = smbus_pkg::ST_STOP;
				end else if (q.master && cmdStart) begin
					d.st = smbus_pkg::ST_RSTART;
					d.pendAddr = txData;
				end else if (!q.master && cmdStop) begin
					d.st = smbus_pkg::ST_IDLE;
					d.sclOe = 1'b0;
					d.sdaOe = 1'b0;
				end else if (cmdGo) begin
					// Next byte handed over whole
					if (isTx(q.master, 1'b0, q.dirRead)) begin
						d.shift = txData;
					end
					d.ackAssert = ackOut;
					d.stopAfter = 1'b0;
					d.bitCnt = smbus_pkg::FIRST_BIT;
					d.sclOe = q.master;
					d.st = smbus_pkg::ST_LOW;
				end
			end
			smbus_pkg::ST_STOP: begin
				// SDA low under low SCL, then release SCL
				if (!q.sdaOe) begin
					if (!bus.sclS) begin
						d.sdaOe = 1'b1;
					end
				end else if (bitClockTick) begin
					d.sclOe = 1'b0;
					d.stopAfter = 1'b1;
					d.st = smbus_pkg::ST_RISE;
				end
			end
			smbus_pkg::ST_RSTART: begin
				// SDA released first so it can fall again
				d.sdaOe = 1'b0;
				if (bitClockTick && !q.sdaOe) begin
					d.sclOe = 1'b0;
					d.stopAfter = 1'b0;
					d.st = smbus_pkg::ST_RISE;
				end
			end
			smbus_pkg::ST_RISE: begin
				// SDA moves only under a released high clock
				if (bus.sclS && bitClockTick) begin
					if (q.stopAfter) begin
						d.sdaOe = 1'b0;
						d.master = 1'b0;
						d.st = smbus_pkg::ST_IDLE;
					end else begin
						d.sdaOe = 1'b1;
						d.addrPh = 1'b1;
						d.shift = q.pendAddr;
						d.dirRead = q.pendAddr[smbus_pkg::ADDR_DIR_BIT];
						d.st = smbus_pkg::ST_START;
					end
				end
			end
			default: begin
				d.st = smbus_pkg::ST_IDLE;
			end
		endcase

		// Byte bookkeeping at the end of every bit
		if (adv) begin
			d.tickCnt = '0;
			d.st = smbus_pkg::ST_LOW;
			if (q.bitCnt < smbus_pkg::LAST_DATA_BIT) begin
				d.bitCnt = q.bitCnt + 4'h1;
			end else if (q.bitCnt == smbus_pkg::LAST_DATA_BIT) begin
				d.rxByte = d.shift;
				d.bitCnt = smbus_pkg::ACK_BIT;
				if (q.addrPh && !q.master) begin
					d.dirRead = d.shift[smbus_pkg::ADDR_DIR_BIT];
				end
				if (curTx) begin
					d.ackAssert = 1'b0;
				end else if (q.addrPh && !q.master && slaveInhibit) begin
					d.ackAssert = 1'b0;
				end else if (hwAckEnable) begin
					d.ackAssert = (q.addrPh && !q.master) ?
						(d.shift[7:1] == slaveAddr) : ackOut;
				end else begin
					// Receiving without hardware ACK: event before ACK
					d.st = smbus_pkg::ST_HOLD;
					d.evt = 1'b1;
					d.sclOe = 1'b1;
				end
			end else begin
				d.addrPh = 1'b0;
				d.bitCnt = smbus_pkg::FIRST_BIT;
				if (!q.master && q.addrPh && !q.ackAssert) begin
					d.st = smbus_pkg::ST_IDLE;
					d.sdaOe = 1'b0;
				end else if (!q.master && curTx && !d.ackSeen) begin
					d.st = smbus_pkg::ST_IDLE;
					d.evt = 1'b1;
					d.sdaOe = 1'b0;
				end else if (hwAckEnable || curTx ||
					isTx(q.master, 1'b0, q.dirRead)) begin
					// Event after ACK, clock held until software acts
					d.st = smbus_pkg::ST_WAIT;
					d.evt = 1'b1;
					d.sclOe = 1'b1;
				end else if (q.master && q.stopAfter) begin
					d.st = smbus_pkg::ST_STOP;
				end
			end
		end

		// Bus conditions seen while we are not the master
		if (!q.master && bus.stopDet) begin
			d.st = smbus_pkg::ST_IDLE;
			d.sclOe = 1'b0;
			d.sdaOe = 1'b0;
		end else if (!q.master && bus.startDet) begin
			d.st = smbus_pkg::ST_LOW;
			d.bitCnt = smbus_pkg::FIRST_BIT;
			d.addrPh = 1'b1;
			d.sclOe = 1'b0;
			d.sdaOe = 1'b0;
		end

		// SDA changes only while SCL is seen low
		if (d.st == smbus_pkg::ST_LOW && !bus.sclS) begin
			d.sdaOe = sdaLow(d);
		end

		// Disable or SCL low timeout abandons the transfer; only disable drops a queued start
		if (!enable || tmoHit) begin
			d.st = smbus_pkg::ST_IDLE;
			d.sclOe = 1'b0;
			d.sdaOe = 1'b0;
			d.master = 1'b0;
			d.startPend = d.startPend && enable;
			d.tmo = d.tmo || tmoHit;
		end
		d.txMode = isTx(d.master, d.addrPh, d.dirRead);
	end

	// Every field of the state record registered here
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q <= '{st: smbus_pkg::ST_IDLE, lowLevel: smbus_pkg::DRIVE_LEVEL,
				default: '0};
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// Outputs, all from flip-flops
	// ****************************************
	assign sclOut            = q.lowLevel;
	assign sdaOut            = q.lowLevel;
	assign sclOe             = q.sclOe;
	assign sdaOe             = q.sdaOe;
	assign sclLowTimerReload = q.reload;
	assign byteEvent         = q.evt;
	assign arbLostEvent      = q.arb;
	assign sclTimeoutEvent   = q.tmo;
	assign rxData            = q.rxByte;
	assign ackReceived       = q.ackSeen;
	assign masterMode        = q.master;
	assign transmitMode      = q.txMode;
	assign busBusy           = q.busy;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_start_when_free;
		(q.st == smbus_pkg::ST_IDLE && d.st == smbus_pkg::ST_START)
			|-> bus.busFree;
	endproperty
	a_start_when_free: assert property (p_start_when_free)
		else $error("master start on busy bus");

	property p_pending_start;
		(q.st == smbus_pkg::ST_IDLE && q.startPend && bus.busFree && enable
			&& !tmoHit && !bus.startDet && !bus.stopDet)
			|=> (q.st == smbus_pkg::ST_START && sdaOe);
	endproperty
	a_pending_start: assert property (p_pending_start)
		else $error("queued start not issued on free bus");

	property p_arb_loss;
		(q.st == smbus_pkg::ST_HIGH && q.master && !q.sampled && bus.sclS
			&& curTx && q.bitCnt != smbus_pkg::ACK_BIT && !q.sdaOe
			&& !bus.sdaS && enable && !tmoHit)
			|=> (!masterMode && arbLostEvent && !sclOe);
	endproperty
	a_arb_loss: assert property (p_arb_loss)
		else $error("arbitration loss not handled");

	property p_timeout_reset;
		(enable && tmoHit) |=> (q.st == smbus_pkg::ST_IDLE && !sclOe
			&& !sdaOe && sclTimeoutEvent) [*1];
	endproperty
	a_timeout_reset: assert property (p_timeout_reset)
		else $error("timeout did not release the bus");

	property p_reload_follows;
		(enable && sclLowTimeoutEnable) |=>
			(sclLowTimerReload == $past(bus.sclS));
	endproperty
	a_reload_follows: assert property (p_reload_follows)
		else $error("timeout timer reload not tied to SCL high");

	property p_hold_rx_only;
		(q.st != smbus_pkg::ST_HOLD ##1 q.st == smbus_pkg::ST_HOLD) |->
			(q.bitCnt == smbus_pkg::ACK_BIT && !curTx && sclOe && byteEvent);
	endproperty
	a_hold_rx_only: assert property (p_hold_rx_only)
		else $error("pre-acknowledge hold outside a received byte");

	property p_stretch_wait;
		(q.st == smbus_pkg::ST_HIGH && q.master && !q.sampled && !bus.sclS
			&& enable && !tmoHit) |=> (q.st == smbus_pkg::ST_HIGH && !sclOe);
	endproperty
	a_stretch_wait: assert property (p_stretch_wait)
		else $error("master advanced while SCL held low");

	property p_ack_drive;
		(q.st == smbus_pkg::ST_LOW && q.bitCnt == smbus_pkg::ACK_BIT && !curTx
			&& q.ackAssert && !bus.sclS && enable && !tmoHit
			&& !bus.startDet) |=> sdaOe;
	endproperty
	a_ack_drive: assert property (p_ack_drive)
		else $error("receiver failed to drive acknowledge");
endmodule : smbus_master_slave_controller

// file: include/smbus_pkg.sv
package smbus_pkg;

	// ****************************************
	// Bit framing
	// ****************************************
	localparam int unsigned CLK_PER_BIT_MIN = 20;   // Fewest sysclk per bit
	localparam logic [3:0]  FIRST_BIT       = 4'h0; // First bit of a byte
	localparam logic [3:0]  LAST_DATA_BIT   = 4'h7; // Eighth bit of a byte
	localparam logic [3:0]  ACK_BIT         = 4'h8; // Acknowledge slot
	localparam int          ADDR_DIR_BIT    = 0;    // Direction in address
	localparam logic        DIR_READ        = 1'b1; // Read from slave
	localparam logic        ACK_LEVEL       = 1'b0; // SDA level of an ACK

	// ****************************************
	// Bit clock timing, in source overflows
	// ****************************************
	localparam logic [1:0]  HIGH_TICKS         = 2'h2; // SCL high, low is one
	localparam int          FREE_TIMEOUT_TICKS = 10;   // Idle ticks to free

	// ****************************************
	// Line levels
	// ****************************************
	localparam logic        LINE_IDLE   = 1'b1; // Pulled-up bus level
	localparam logic        DRIVE_LEVEL = 1'b0; // Only level ever driven

	// ****************************************
	// Controller state
	// ****************************************
	typedef enum logic [3:0] {
		ST_IDLE, ST_START, ST_LOW, ST_HIGH, ST_HOLD,
		ST_WAIT, ST_STOP, ST_RSTART, ST_RISE
	} state_t;

	typedef struct packed {
		state_t     st;        // Sequencer state
		logic [3:0] bitCnt;    // Bit within byte, 8 is acknowledge
		logic [7:0] shift;     // Serial shifter
		logic [7:0] pendAddr;  // Address byte of queued start
		logic [7:0] rxByte;    // Last completed byte
		logic [1:0] tickCnt;   // Ticks spent in SCL high
		logic       sampled;   // SDA taken this high phase
		logic       master;    // We own the clock
		logic       addrPh;    // Address byte in flight
		logic       dirRead;   // Transaction reads from slave
		logic       ackAssert; // ACK (not NACK) to send
		logic       ackSeen;   // ACK seen on last byte
		logic       stopAfter; // Stop, not restart, on the rise
		logic       startPend; // Master start queued
		logic       sclOe;     // Pull SCL low
		logic       sdaOe;     // Pull SDA low
		logic       evt;       // Byte event flag
		logic       arb;       // Arbitration lost flag
		logic       tmo;       // SCL low timeout flag
		logic       reload;    // Timeout timer reload request
		logic       busy;      // Bus seen busy
		logic       txMode;    // We drive SDA on data bits
		logic       lowLevel;  // Constant driven level
	} ctl_t;

endpackage : smbus_pkg

// file: include/bus_sense_if.sv
// Sampled line view shared by sampler, monitor and sequencer
interface bus_sense_if;
	logic sclS;     // Synchronised SCL
	logic sdaS;     // Synchronised SDA
	logic sclRise;  // SCL went high
	logic sclFall;  // SCL went low
	logic startDet; // START seen on the bus
	logic stopDet;  // STOP seen on the bus
	logic busFree;  // Bus may be taken

	modport sampler (output sclS, sdaS, sclRise, sclFall, startDet, stopDet);
	modport monitor (input sclS, sdaS, startDet, stopDet, output busFree);
	modport ctrl    (input sclS, sdaS, sclRise, sclFall, startDet, stopDet,
		busFree);
endinterface : bus_sense_if

// file: core/line_sampler.sv
module line_sampler (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic sclIn,
	input  wire logic sdaIn,
	bus_sense_if.sampler bus
);
	// ****************************************
	// Two-stage synchronisers plus history
	// ****************************************
	typedef struct packed {
		logic sclM; // First stage, read by second only
		logic sdaM;
		logic sclS; // Second stage
		logic sdaS;
		logic sclP; // Previous stable value
		logic sdaP;
	} samp_t;

	samp_t q;
	samp_t d;

	// Shift pins through; edges come from stable stages only
	always_comb begin
		d = q;
		d.sclM = sclIn;
		d.sdaM = sdaIn;
		d.sclS = q.sclM;
		d.sdaS = q.sdaM;
		d.sclP = q.sclS;
		d.sdaP = q.sdaS;
	end

	// Reset to released lines so no false edge appears
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q <= '{default: smbus_pkg::LINE_IDLE};
		end else begin
			q <= d;
		end
	end

	assign bus.sclS     = q.sclS;
	assign bus.sdaS     = q.sdaS;
	assign bus.sclRise  = q.sclS && !q.sclP;
	assign bus.sclFall  = !q.sclS && q.sclP;
	assign bus.startDet = q.sclS && q.sclP && q.sdaP && !q.sdaS;
	assign bus.stopDet  = q.sclS && q.sclP && !q.sdaP && q.sdaS;

	// START flagged exactly when SDA falls under a high clock
	property p_start_det;
		@(posedge clk) disable iff (sys_rst)
		(q.sclS && q.sclP && $fell(q.sdaS)) |-> bus.startDet;
	endproperty
	a_start_det: assert property (p_start_det)
		else $error("START under high SCL not flagged");
endmodule : line_sampler

// file: core/bus_free_monitor.sv
module bus_free_monitor #(
	parameter int FREE_TICKS = smbus_pkg::FREE_TIMEOUT_TICKS
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic bitClockTick,
	input  wire logic busFreeTimeoutEnable,
	bus_sense_if.monitor bus
);
	localparam int CW = $clog2(FREE_TICKS + 2);
	localparam logic [CW-1:0] LIMIT = CW'(FREE_TICKS + 1); // More than N

	// ****************************************
	// Busy tracking
	// ****************************************
	typedef struct packed {
		logic          busy; // START or low SCL seen, no end yet
		logic [CW-1:0] cnt;  // Ticks with both lines high
	} mon_t;

	mon_t q;
	mon_t d;

	// Counting needs the bit clock even for a pure slave
	always_comb begin
		d = q;
		if (!bus.sclS || !bus.sdaS) begin
			d.cnt = '0;
		end else if (bitClockTick && q.cnt != LIMIT) begin
			d.cnt = q.cnt + CW'(1);
		end
		if (bus.startDet || !bus.sclS) begin
			d.busy = 1'b1;
		end else if (bus.stopDet) begin
			d.busy = 1'b0;
		end else if (busFreeTimeoutEnable && q.cnt == LIMIT) begin
			d.busy = 1'b0;
		end
	end

	// Assume busy out of reset until idle is proven
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q <= '{busy: 1'b1, cnt: '0};
		end else begin
			q <= d;
		end
	end

	assign bus.busFree = !q.busy;

	// Idle past the limit frees the bus on the next edge
	property p_free_timeout;
		@(posedge clk) disable iff (sys_rst)
		(busFreeTimeoutEnable && q.cnt == LIMIT && bus.sclS && !bus.startDet)
			|=> bus.busFree;
	endproperty
	a_free_timeout: assert property (p_free_timeout)
		else $error("bus not freed after idle timeout");
endmodule : bus_free_monitor

// file: tb/smbus_slave_model.sv
// ****************************************
// Far-side slave on the wired bus
// ****************************************
module smbus_slave_model #(
	parameter logic [6:0] ADDR = 7'h2A // Own address of this slave
) (
	input  wire logic       scl,
	input  wire logic       sda,
	output logic            sdaOe,
	output logic [7:0]      lastByte,
	output logic            stopSeen
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] n;     // Bits taken in this byte
	logic [7:0] sh;    // Incoming shifter
	logic       on;    // Inside a frame for us
	logic       first; // Address byte pending
	initial begin
		sdaOe = 0;
		n = 0;
		on = 0;
		first = 0;
		stopSeen = 0;
		lastByte = 0;
	end
	// Frame edges: SDA moving while SCL high
	always @(negedge sda) if (scl) begin
		on = 1;
		first = 1;
		n = 0;
		stopSeen = 0;
	end
	always @(posedge sda) if (scl) begin
		on = 0;
		stopSeen = 1;
	end
	// Data sampled on SCL rise, MSB first
	always @(posedge scl) if (on && n < 8) begin
		sh = {sh[6:0], sda};
		n = n + 1;
	end
	// Only pulls low; a foreign address gets no ACK, line floats high
	always @(negedge scl) begin
		if (sdaOe) begin
			sdaOe = 0;
			n = 0;
		end else if (on && n == 8) begin
			if (first && sh[7:1] != ADDR) begin
				on = 0;
			end else begin
				lastByte = sh;
				sdaOe = 1;
			end
			first = 0;
		end
	end
endmodule : smbus_slave_model

// file: tb/test_smbus_master_slave_controller.sv
// ****************************************
// Master write, NACK, timeout, slave ACK
// ****************************************
module test_smbus_master_slave_controller;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk, sysRst, tick, cmdStart, cmdStop, cmdGo, flagClear;
	logic       timerOvf, sclOe, sdaOe, modelSdaOe, reload, byteEvent;
	logic       tmo, ackRx, master, busy, stopSeen;
	logic       hwAck, en, mScl, mSda, arbLost, txMode, sclLvl, sdaLvl;
	logic [7:0] txData, rxData, modelByte;
	int         errTotal = 0, compares = 0, cycles = 0, tickCnt = 0;
	wire        scl = ~((sclOe & ~sclLvl) | mScl);              // Pulled up
	wire        sda = ~((sdaOe & ~sdaLvl) | modelSdaOe | mSda); // Wired AND
	smbus_master_slave_controller #(.FREE_TICKS(3)) dut (.clk(clk),
		.sys_rst(sysRst), .enable(en), .slaveInhibit(1'b0),
		.hwAckEnable(hwAck), .sclLowTimeoutEnable(1'b1),
		.busFreeTimeoutEnable(1'b1), .slaveAddr(7'h33), .bitClockTick(tick),
		.sclLowTimerOvf(timerOvf), .cmdStart(cmdStart), .cmdStop(cmdStop),
		.cmdGo(cmdGo), .txData(txData), .ackOut(1'b1), .flagClear(flagClear),
		.sclIn(scl), .sdaIn(sda), .sclOut(sclLvl), .sclOe(sclOe),
		.sdaOut(sdaLvl), .sdaOe(sdaOe), .sclLowTimerReload(reload),
		.byteEvent(byteEvent), .arbLostEvent(arbLost),
		.sclTimeoutEvent(tmo), .rxData(rxData), .ackReceived(ackRx),
		.masterMode(master), .transmitMode(txMode), .busBusy(busy));
	smbus_slave_model slave (.scl(scl), .sda(sda), .sdaOe(modelSdaOe),
		.lastByte(modelByte), .stopSeen(stopSeen));
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	// Bit clock source: one tick in eight gives 24 clk a bit
	always @(negedge clk) begin
		tickCnt <= (tickCnt == 7) ? 0 : tickCnt + 1;
		tick <= (tickCnt == 7);
	end
	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errTotal++;
			conclude();
		end
	end
	task check(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			errTotal++;
			$display("BAD %0t got %h want %h", $time, seen, exp);
		end
	endtask : check
	// One-cycle command pulse
	task cmd(input logic s, input logic t, input logic g,
		input logic [7:0] d);
		@(negedge clk);
		{cmdStart, cmdStop, cmdGo, txData} = {s, t, g, d};
		@(negedge clk);
		{cmdStart, cmdStop, cmdGo} = 3'h0;
	endtask : cmd
	// Bounded wait for the byte flag, then clear it
	task waitEvt;
		for (int i = 0; i < 3000 && byteEvent !== 1'b1; i++) @(negedge clk);
		check(byteEvent, 8'h01);
		flagClear = 1;
		@(negedge clk);
		flagClear = 0;
	endtask : waitEvt
	task writeXfer;
		cmd(1, 0, 0, 8'h54);
		waitEvt();
		check(ackRx, 8'h01);
		check(master, 8'h01);
		check(modelByte, 8'h54);
		check(rxData, 8'h54);
		check(txMode, 8'h01);
		cmd(0, 0, 1, 8'hA5);
		waitEvt();
		check(ackRx, 8'h01);
		check(modelByte, 8'hA5);
		check(rxData, 8'hA5);
		cmd(0, 1, 0, 8'h00);
		for (int i = 0; i < 300 && stopSeen !== 1'b1; i++) @(negedge clk);
		check(stopSeen, 8'h01);
		check(sclOe, 8'h00);
		check({6'h00, sclLvl, sdaLvl}, 8'h00);
		check(arbLost, 8'h00);
	endtask : writeXfer
	// Unknown address, then SCL held low until the timer fires
	task nackTimeout;
		cmd(1, 0, 0, 8'h22);
		waitEvt();
		check(ackRx, 8'h00);
		repeat (2) @(negedge clk);
		check(reload, 8'h00);
		@(negedge clk);
		timerOvf = 1;
		@(negedge clk);
		timerOvf = 0;
		repeat (3) @(negedge clk);
		check(tmo, 8'h01);
		check({6'h00, sclOe, sdaOe}, 8'h00);
	endtask : nackTimeout
	// Far-master bit: SDA moves under low SCL, waits out stretching
	task mBit(input logic b, output logic s);
		mSda = !b;
		repeat (13) @(negedge clk);
		mScl = 0;
		wait (scl === 1'b1);
		repeat (13) @(negedge clk);
		s = sda;
		mScl = 1;
		@(negedge clk);
	endtask : mBit
	// Bench masters the bus; block answers as slave with hardware ACK
	task slaveAck;
		logic       s;
		logic [7:0] a;
		a = 8'h66;
		hwAck = 1;
		mSda = 1;
		repeat (13) @(negedge clk);
		mScl = 1;
		@(negedge clk);
		for (int i = 7; i >= 0; i--) mBit(a[i], s);
		mBit(1'b1, s);
		repeat (8) @(negedge clk);
		check(s, 8'h00);
		check(byteEvent, 8'h01);
		check(rxData, a);
		check({6'h00, master, txMode}, 8'h00);
		cmd(0, 1, 0, 8'h00);
		mSda = 1;
		repeat (13) @(negedge clk);
		mScl = 0;
		wait (scl === 1'b1);
		repeat (13) @(negedge clk);
		mSda = 0;
		repeat (6) @(negedge clk);
		check(busy, 8'h00);
	endtask : slaveAck
	task conclude;
		if (errTotal == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude
	initial begin
		{sysRst, cmdStart, cmdStop, cmdGo, flagClear, timerOvf} = 6'h20;
		{en, hwAck, mScl, mSda} = 4'h8;
		txData = 8'h00;
		repeat (5) @(negedge clk);
		sysRst = 0;
		@(negedge clk);
		check(busy, 8'h01);
		writeXfer();
		nackTimeout();
		slaveAck();
		conclude();
	end
endmodule : test_smbus_master_slave_controller
